// ---- ida_irq_ctrl.sv ----
/*
 * interrupt detect, latch, dispatch and acknowledge for the processor core.
 * assumes fetch boundary, ack decode/read phase and trap strobes come from
 * the core pipeline on clk; on-chip peripheral requests are one-cycle
 * pulses on clk; the external pins are asynchronous.
 */
`timescale 1ns/1ns
module ida_irq_ctrl #(
    parameter int NUM_EXT = 4,
    parameter int NUM_SRC = 9
) (
    input wire logic clk,                      // core clock, 125 MHz
    input wire logic rst_n,                    // async reset, active low
    input wire logic clkEn,                    // freezes all state while low
    input wire logic [NUM_EXT-1:0] extIrqPinN, // ext_irq_pin_zero..three, active low
    input wire logic edgeDetectSelect,         // 1 = falling-edge mode
    input wire logic mcMode,                   // 1 = microcomputer/bootloader map
    input wire logic serialTxIrq,              // serial transmit event
    input wire logic serialRxIrq,              // serial receive event
    input wire logic firstTimerIrq,            // timer 0 event
    input wire logic secondTimerIrq,           // timer 1 event
    input wire logic dmaDoneIrq,               // dma done event
    input wire logic [NUM_SRC-1:0] cpuIrqEnable, // sources the cpu accepts
    input wire logic [NUM_SRC-1:0] dmaIrqEnable, // sources the dma accepts
    input wire logic fetchBoundary,            // instruction-fetch boundary
    input wire logic swClearValid,             // software flag clear strobe
    input wire logic [NUM_SRC-1:0] swClearMask, // flags to clear
    input wire logic ackDecode,                // ack instruction in decode phase
    input wire logic ackRead,                  // ack instruction in read phase
    input wire logic trapValid,                // trap instruction executed
    input wire logic [4:0] trapNum,            // trap number 0..27
    output logic [NUM_SRC-1:0] pendFlags_q,    // pending flag per source
    output logic cpuTakeValid_q,               // cpu takes an interrupt
    output logic [3:0] cpuTakeSrc_q,           // source number taken
    output logic [23:0] cpuVector_q,           // vector / branch location
    output logic dmaTrigger_q,                 // dma synchronisation event
    output logic [3:0] dmaTakeSrc_q,           // source the dma took
    output logic trapTakeValid_q,              // trap vector valid
    output logic [23:0] trapVector_q,          // trap vector / branch location
    output logic [23:0] resetVector_q,         // reset vector location
    output logic irqAckStrobeN_q               // irq_ack_strobe, active low
);
    ida_sync_if #(.NUM_EXT(NUM_EXT)) syncBus ();

    ida_pin_sync #(.NUM_EXT(NUM_EXT)) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .clkEn(clkEn),
        .pinN(extIrqPinN),
        .syncOut(syncBus)
    );

    // detection
    logic [NUM_SRC-1:0] setVec;
    logic [NUM_EXT-1:0] extDetect;
    always_comb begin
        extDetect = edgeDetectSelect ? syncBus.fallEdge : syncBus.levelLow;
        setVec = {dmaDoneIrq, secondTimerIrq, firstTimerIrq, serialRxIrq, serialTxIrq,
                  extDetect};
    end

    // dispatch selection: lowest source number wins
    logic [NUM_SRC-1:0] cpuHit, dmaHit, takeClr, clrVec;
    logic [3:0] cpuSel, dmaSel;
    always_comb begin
        cpuHit = pendFlags_q & cpuIrqEnable;
        dmaHit = pendFlags_q & dmaIrqEnable;
        cpuSel = 4'h0;
        dmaSel = 4'h0;
        for (int k = NUM_SRC - 1; k >= 0; k--) begin
            if (cpuHit[k]) begin
                cpuSel = 4'(k);
            end
            if (dmaHit[k]) begin
                dmaSel = 4'(k);
            end
        end
        takeClr = '0;
        if (fetchBoundary) begin
            if (|cpuHit) begin
                takeClr[cpuSel] = 1'b1;
            end
            if (|dmaHit) begin
                takeClr[dmaSel] = 1'b1;
            end
        end
        clrVec = takeClr | (swClearValid ? swClearMask : '0);
    end

    // pending flags and dispatch outputs
    logic [NUM_SRC-1:0] pend_d;
    logic cpuTake_d, dmaTrig_d, trapTake_d;
    logic [3:0] cpuSrc_d, dmaSrc_d;
    logic [23:0] cpuVec_d, trapVec_d, resetVec_d;
    always_comb begin
        pend_d = pendFlags_q;
        cpuTake_d = cpuTakeValid_q;
        cpuSrc_d = cpuTakeSrc_q;
        cpuVec_d = cpuVector_q;
        dmaTrig_d = dmaTrigger_q;
        dmaSrc_d = dmaTakeSrc_q;
        trapTake_d = trapTakeValid_q;
        trapVec_d = trapVector_q;
        resetVec_d = resetVector_q;
        if (clkEn) begin
            // a detection in the clearing cycle survives, so a flag can
            // re-arm right after it is cleared
            pend_d = (pendFlags_q & ~clrVec) | setVec;
            cpuTake_d = fetchBoundary && (|cpuHit);
            dmaTrig_d = fetchBoundary && (|dmaHit);
            if (fetchBoundary && (|cpuHit)) begin
                cpuSrc_d = cpuSel;
                cpuVec_d = ida_pkg::srcVector(mcMode, cpuSel);
            end
            if (fetchBoundary && (|dmaHit)) begin
                dmaSrc_d = dmaSel;
            end
            // trap numbers above 27 land in reserved space and are dropped
            trapTake_d = trapValid && (trapNum <= ida_pkg::LAST_TRAP);
            if (trapValid && (trapNum <= ida_pkg::LAST_TRAP)) begin
                trapVec_d = ida_pkg::trapVector(mcMode, trapNum);
            end
            resetVec_d = mcMode ? resetVector_q : ida_pkg::RESET_VECTOR;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pendFlags_q <= ida_pkg::PEND_RESET;
            cpuTakeValid_q <= 1'b0;
            cpuTakeSrc_q <= 4'h0;
            cpuVector_q <= 24'h000000;
            dmaTrigger_q <= 1'b0;
            dmaTakeSrc_q <= 4'h0;
            trapTakeValid_q <= 1'b0;
            trapVector_q <= 24'h000000;
            resetVector_q <= ida_pkg::RESET_VECTOR;
        end else begin
            pendFlags_q <= pend_d;
            cpuTakeValid_q <= cpuTake_d;
            cpuTakeSrc_q <= cpuSrc_d;
            cpuVector_q <= cpuVec_d;
            dmaTrigger_q <= dmaTrig_d;
            dmaTakeSrc_q <= dmaSrc_d;
            trapTakeValid_q <= trapTake_d;
            trapVector_q <= trapVec_d;
            resetVector_q <= resetVec_d;
        end
    end

    // acknowledge strobe
    logic ack_d;
    always_comb begin
        ack_d = irqAckStrobeN_q;
        if (clkEn) begin
            if (ackDecode) begin
                ack_d = 1'b0;
            end else if (ackRead) begin
                ack_d = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irqAckStrobeN_q <= ida_pkg::ACK_IDLE;
        end else begin
            irqAckStrobeN_q <= ack_d;
        end
    end

    // checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    logic cpuPick0Mp, cpuPick0Mc;
    assign cpuPick0Mp = clkEn && fetchBoundary && cpuHit[0] && !mcMode;
    assign cpuPick0Mc = clkEn && fetchBoundary && cpuHit[0] && mcMode;

    sequence s_clear0;
        clkEn && swClearValid && swClearMask[0];
    endsequence
    sequence s_lowAgain0;
        clkEn && !edgeDetectSelect && syncBus.levelLow[0];
    endsequence

    a_level_sets_flag: assert property (
        clkEn && !edgeDetectSelect && syncBus.levelLow[0] |=> pendFlags_q[0])
        else $error("level request did not set pending flag");
    a_edge_sets_flag: assert property (
        clkEn && edgeDetectSelect && syncBus.fallEdge[3] |=> pendFlags_q[3])
        else $error("falling edge did not set pending flag");
    a_edge_ignores_level: assert property (
        clkEn && edgeDetectSelect && !syncBus.fallEdge[1] && !pendFlags_q[1]
        |=> !pendFlags_q[1])
        else $error("edge mode set a flag without an edge");
    a_take_at_boundary: assert property (
        $rose(cpuTakeValid_q) |-> $past(fetchBoundary))
        else $error("cpu take outside fetch boundary");
    a_take_latency: assert property (
        clkEn && fetchBoundary && (|cpuHit) |=> cpuTakeValid_q
        && (!pendFlags_q[cpuTakeSrc_q] || $past(setVec[cpuSel])))
        else $error("cpu take not one cycle after boundary");
    a_mp_vector: assert property (
        cpuPick0Mp |=> cpuVector_q == 24'h000001)
        else $error("wrong microprocessor vector");
    a_mc_vector: assert property (
        cpuPick0Mc |=> cpuVector_q == 24'h809fc1)
        else $error("wrong microcomputer branch location");
    a_trap_vector: assert property (
        clkEn && trapValid && trapNum == 5'h1b
        |=> trapTakeValid_q && trapVector_q == (mcMode ? 24'h809ffb : 24'h00003b))
        else $error("wrong trap vector");
    a_ack_assert: assert property (
        clkEn && ackDecode |=> !irqAckStrobeN_q)
        else $error("ack strobe not asserted at decode");
    a_ack_release: assert property (
        clkEn && ackRead && !ackDecode |=> irqAckStrobeN_q)
        else $error("ack strobe not released at read");
    a_ack_cause: assert property (
        $fell(irqAckStrobeN_q) |-> $past(ackDecode))
        else $error("ack strobe without ack instruction");
    a_rearm_after_clear: assert property (
        s_clear0 ##1 s_lowAgain0 |=> pendFlags_q[0])
        else $error("flag could not re-arm two cycles after clear");
endmodule

// ---- ida_irq_source.sv ----
/*
 * model of the external interrupt sources driving the active-low pins.
 * assumes the bench raises fire for one clock; idle pins are pulled up.
 */
`timescale 1ns/1ns
module ida_irq_source (
    input wire logic clk,          // core clock
    input wire logic [3:0] fire,   // start one low pulse per pin
    input wire logic [3:0] lowLen, // pulse length in clocks
    output logic [3:0] pinN        // active-low request pins
);
    // pins read high from the first clock on; reset covers the time before
    int cnt[4] = '{default: 0};
    // level pulses run two to eight clocks, edge pulses two clocks or more
    always @(posedge clk) begin
        for (int i = 0; i < 4; i++) begin
            if (fire[i]) cnt[i] = lowLen;
            else if (cnt[i] > 0) cnt[i]--;
            pinN[i] <= (cnt[i] == 0);
        end
    end
endmodule

// ---- ida_pin_sync.sv ----
/*
 * three-stage synchroniser and falling-edge detector for the active-low
 * external interrupt pins.
 * assumes pins are asynchronous to clk; a change is accepted once the
 * second and third stages agree.
 */
`timescale 1ns/1ns
module ida_pin_sync #(
    parameter int NUM_EXT = 4
) (
    input wire logic clk,                   // core clock
    input wire logic rst_n,                 // async reset, active low
    input wire logic clkEn,                 // freezes all state while low
    input wire logic [NUM_EXT-1:0] pinN,    // raw active-low request pins
    ida_sync_if.src syncOut                 // filtered level and edge
);
    genvar i;
    generate
        for (i = 0; i < NUM_EXT; i++) begin : g_pin
            logic [2:0] stage_q, stage_d;
            logic filt_q, filt_d;
            logic fall_q, fall_d;
            always_comb begin
                stage_d = stage_q;
                filt_d = filt_q;
                fall_d = fall_q;
                if (clkEn) begin
                    stage_d = {stage_q[1:0], pinN[i]};
                    // first stage is only read by the second
                    filt_d = (stage_q[1] == stage_q[2]) ? stage_q[2] : filt_q;
                    fall_d = filt_q & ~filt_d;
                end
            end
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    stage_q <= 3'h7;
                    filt_q <= 1'b1;
                    fall_q <= 1'b0;
                end else begin
                    stage_q <= stage_d;
                    filt_q <= filt_d;
                    fall_q <= fall_d;
                end
            end
            assign syncOut.levelLow[i] = ~filt_q;
            assign syncOut.fallEdge[i] = fall_q;
        end
    endgenerate
endmodule

// ---- ida_pkg.sv ----
/*
 * constants, vector map and source numbering for the interrupt detect and
 * acknowledge block.
 * assumes one core clock at 125 MHz whose rising edge stands for the
 * phase-one falling edge at which interrupt pins are sampled.
 */
// Function
// - external request pins are asynchronous; synchronise, sample each phase-one cycle
// - detection mode selectable: level-sensitive or edge-sensitive
// - cpu and dma take detected interrupts only at instruction-fetch boundaries
// - edge select high: falling pin edges detected by synchronous logic
// - a cleared flag can be set again from its source two cycles later
// - response follows a fixed cycle sequence; late inputs cost one extra cycle
// - ack strobe asserts at decode phase, releases at read phase of ack instruction
// - ack strobe pulses only when the ack instruction runs, at any time
// - microprocessor mode vectors: reset 00, ints 01-06, 09-0b, traps 20-3b
// - microcomputer mode branches: 809fc1 to 809fcb, traps 809fe0 to 809ffb
package ida_pkg;
    localparam int NUM_EXT = 4;
    localparam int NUM_SRC = 9;
    localparam int NUM_TRAP = 28;
    localparam int SYNC_STAGES = 3;
    // source numbering, lowest number wins
    localparam logic [3:0] SRC_SERIAL_TX = 4'h4;
    localparam logic [3:0] SRC_SERIAL_RX = 4'h5;
    localparam logic [3:0] SRC_TIMER0 = 4'h6;
    localparam logic [3:0] SRC_TIMER1 = 4'h7;
    localparam logic [3:0] SRC_DMA_DONE = 4'h8;
    // vector bases
    localparam logic [23:0] MP_BASE = 24'h000000;
    localparam logic [23:0] MC_BASE = 24'h809fc0;
    localparam logic [23:0] MP_TRAP_BASE = 24'h000020;
    localparam logic [23:0] MC_TRAP_BASE = 24'h809fe0;
    localparam logic [23:0] RESET_VECTOR = 24'h000000;
    localparam logic [4:0] LAST_TRAP = 5'h1b;
    // offsets within a base for each source
    localparam logic [23:0] OFS_EXT0 = 24'h000001;
    localparam logic [23:0] OFS_SERIAL_TX = 24'h000005;
    localparam logic [23:0] OFS_SERIAL_RX = 24'h000006;
    localparam logic [23:0] OFS_TIMER0 = 24'h000009;
    localparam logic [23:0] OFS_TIMER1 = 24'h00000a;
    localparam logic [23:0] OFS_DMA_DONE = 24'h00000b;
    // reset values
    localparam logic [8:0] PEND_RESET = 9'h000;
    localparam logic ACK_IDLE = 1'b1;

    function automatic logic [23:0] srcOffset(input logic [3:0] idx);
        logic [23:0] ofs;
        ofs = OFS_EXT0;
        case (idx)
            4'h0, 4'h1, 4'h2, 4'h3: ofs = OFS_EXT0 + {20'h00000, idx};
            SRC_SERIAL_TX: ofs = OFS_SERIAL_TX;
            SRC_SERIAL_RX: ofs = OFS_SERIAL_RX;
            SRC_TIMER0: ofs = OFS_TIMER0;
            SRC_TIMER1: ofs = OFS_TIMER1;
            SRC_DMA_DONE: ofs = OFS_DMA_DONE;
            default: ofs = OFS_EXT0;
        endcase
        return ofs;
    endfunction

    function automatic logic [23:0] srcVector(input logic mcMode, input logic [3:0] idx);
        return (mcMode ? MC_BASE : MP_BASE) + srcOffset(idx);
    endfunction

    function automatic logic [23:0] trapVector(input logic mcMode, input logic [4:0] num);
        return (mcMode ? MC_TRAP_BASE : MP_TRAP_BASE) + {19'h00000, num};
    endfunction
endpackage

// ---- ida_sync_if.sv ----
/*
 * carrier between the pin synchroniser and the controller.
 * assumes both ends run on the same core clock.
 */
`timescale 1ns/1ns
interface ida_sync_if #(
    parameter int NUM_EXT = 4
);
    logic [NUM_EXT-1:0] levelLow;
    logic [NUM_EXT-1:0] fallEdge;
    modport src (output levelLow, output fallEdge);
    modport dst (input levelLow, input fallEdge);
endinterface

// ---- testbench.sv ----
/*
 * self-checking bench for the interrupt detect and acknowledge block.
 * assumes inputs change on the falling clock edge; clkEn is high except
 * in the freeze scenario.
 */
`timescale 1ns/1ns
module testbench;
    logic clk, rst_n, eds, mc, tx, rx, t0, t1, dd, fb, swv, ackD, ackR, trv;
    logic [3:0] fire, lowLen, pinN, takeSrc, dmaSrc;
    logic [4:0] trapNum;
    logic [8:0] cpuEn, dmaEn, swMask, pend;
    logic cpuTake, dmaTrig, trapTake, ackN, ce;
    logic [23:0] cpuVec, trapVec, rstVec;
    int failures = 0;
    int n_tests = 0;

    ida_irq_source ida_irq_source_i (.clk(clk), .fire(fire), .lowLen(lowLen), .pinN(pinN));
    ida_irq_ctrl ida_irq_ctrl_i (.clk(clk), .rst_n(rst_n), .clkEn(ce), .extIrqPinN(pinN),
        .edgeDetectSelect(eds), .mcMode(mc), .serialTxIrq(tx), .serialRxIrq(rx),
        .firstTimerIrq(t0), .secondTimerIrq(t1), .dmaDoneIrq(dd), .cpuIrqEnable(cpuEn),
        .dmaIrqEnable(dmaEn), .fetchBoundary(fb), .swClearValid(swv), .swClearMask(swMask),
        .ackDecode(ackD), .ackRead(ackR), .trapValid(trv), .trapNum(trapNum),
        .pendFlags_q(pend), .cpuTakeValid_q(cpuTake), .cpuTakeSrc_q(takeSrc),
        .cpuVector_q(cpuVec), .dmaTrigger_q(dmaTrig), .dmaTakeSrc_q(dmaSrc),
        .trapTakeValid_q(trapTake), .trapVector_q(trapVec), .resetVector_q(rstVec),
        .irqAckStrobeN_q(ackN));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic wrap_up;
        if (failures == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic firePin(input int i, input logic [3:0] len);
        fire[i] = 1'b1;
        lowLen = len;
        tick(1);
        fire = 4'h0;
    endtask

    task automatic waitPend(input int i);
        int k;
        for (k = 0; k < 30 && pend[i] !== 1'b1; k++) tick(1);
        if (k == 30) begin
            failures++;
            wrap_up();
        end
    endtask

    task automatic take(input logic [3:0] src, input logic [23:0] vec);
        fb = 1'b1;
        tick(1);
        fb = 1'b0;
        chk(cpuTake, 1'b1);
        chk(takeSrc, src);
        chk(cpuVec, vec);
    endtask

    task automatic pulsePeri(input int k);
        {dd, t1, t0, rx, tx} = 5'h01 << k;
        tick(1);
        {dd, t1, t0, rx, tx} = 5'h00;
    endtask

    task automatic clearFlags(input logic [8:0] m);
        swv = 1'b1;
        swMask = m;
        tick(1);
        swv = 1'b0;
    endtask

    task automatic scLevel;
        eds = 1'b0;
        firePin(0, 4'h2);
        waitPend(0);
        tick(3);
        chk(cpuTake, 1'b0);
        take(4'h0, 24'h000001);
        tick(3);
        chk(pend[0], 1'b0);
    endtask

    task automatic scEdge;
        eds = 1'b1;
        firePin(1, 4'hf);
        waitPend(1);
        clearFlags(9'h002);
        tick(4);
        chk(pend[1], 1'b0);
        tick(12);
        firePin(1, 4'h3);
        waitPend(1);
        take(4'h1, 24'h000002);
        mc = 1'b1;
        for (int i = 0; i < 4; i++) begin
            firePin(i, 4'h3);
            waitPend(i);
            take(i, 24'h809fc1 + i);
        end
        mc = 1'b0;
    endtask

    task automatic scPeri;
        logic [23:0] ofs[5] = '{24'h5, 24'h6, 24'h9, 24'ha, 24'hb};
        for (int m = 0; m < 2; m++) begin
            mc = m;
            for (int k = 0; k < 5; k++) begin
                pulsePeri(k);
                take(4'h4 + k, (m ? 24'h809fc0 : 24'h0) + ofs[k]);
            end
        end
        mc = 1'b0;
        {dd, tx} = 2'b11;
        tick(1);
        {dd, tx} = 2'b00;
        take(4'h4, 24'h000005);
        take(4'h8, 24'h00000b);
    endtask

    task automatic scReflag;
        rx = 1'b1;
        tick(1);
        rx = 1'b0;
        clearFlags(9'h020);
        chk(pend[5], 1'b0);
        rx = 1'b1;
        tick(1);
        rx = 1'b0;
        chk(pend[5], 1'b1);
        clearFlags(9'h020);
    endtask

    task automatic scDma;
        cpuEn = 9'h000;
        dmaEn = 9'h080;
        pulsePeri(3);
        fb = 1'b1;
        tick(1);
        fb = 1'b0;
        chk(dmaTrig, 1'b1);
        chk(dmaSrc, 4'h7);
        chk(cpuTake, 1'b0);
        cpuEn = 9'h1ff;
        dmaEn = 9'h000;
    endtask

    task automatic scTrap;
        logic [4:0] nums[3] = '{5'h00, 5'h1b, 5'h1c};
        for (int m = 0; m < 2; m++) begin
            mc = m;
            for (int j = 0; j < 3; j++) begin
                trv = 1'b1;
                trapNum = nums[j];
                tick(1);
                trv = 1'b0;
                chk(trapTake, j < 2);
                if (j < 2) chk(trapVec, (m ? 24'h809fe0 : 24'h20) + nums[j]);
            end
        end
        mc = 1'b0;
        chk(rstVec, 24'h000000);
    endtask

    // pin held low through a clear: the level re-sets the flag at once
    task automatic scRearm;
        eds = 1'b0;
        firePin(0, 4'h8);
        waitPend(0);
        clearFlags(9'h001);
        chk(pend[0], 1'b1);
        tick(8);
        clearFlags(9'h001);
        chk(pend[0], 1'b0);
    endtask

    // clkEn low: events and strobes arriving meanwhile leave no trace
    task automatic scFreeze;
        ce = 1'b0;
        tx = 1'b1;
        ackD = 1'b1;
        tick(2);
        {tx, ackD, ce} = 3'b001;
        chk(pend[4], 1'b0);
        chk(ackN, 1'b1);
    endtask

    task automatic scAck;
        chk(ackN, 1'b1);
        ackD = 1'b1;
        tick(1);
        ackD = 1'b0;
        chk(ackN, 1'b0);
        tick(2);
        chk(ackN, 1'b0);
        ackR = 1'b1;
        tick(1);
        ackR = 1'b0;
        chk(ackN, 1'b1);
        tick(3);
        chk(ackN, 1'b1);
    endtask

    initial begin
        rst_n = 1'b0;
        {eds, mc, tx, rx, t0, t1, dd, fb, swv, ackD, ackR, trv} = 12'h000;
        fire = 4'h0;
        lowLen = 4'h0;
        trapNum = 5'h00;
        cpuEn = 9'h1ff;
        dmaEn = 9'h000;
        swMask = 9'h000;
        ce = 1'b1;
        tick(2);
        rst_n = 1'b1;
        tick(4);
        scAck();
        scLevel();
        scEdge();
        scPeri();
        scReflag();
        scDma();
        scTrap();
        scRearm();
        scFreeze();
        wrap_up();
    end
endmodule
